/* sup_pkg.sv */
package sup_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned CLK_NS    = 100;
  // power-up delay, nominal figure
  localparam int unsigned POWER_UP_DELAY_TIMER_MS   = 64;
  localparam int unsigned POWER_UP_DELAY_TIMER_CYC  = POWER_UP_DELAY_TIMER_MS * (CLK_HZ / 1000);
  // brown-out dip filter, least time, rounded up
  localparam int unsigned FILT_NS   = 2000;
  localparam int unsigned FILT_CYC  = (FILT_NS + CLK_NS - 1) / CLK_NS;
  // brown-out circuit settling before it reports ready, rounded up
  localparam int unsigned RDY_NS    = 10000;
  localparam int unsigned RDY_CYC   = (RDY_NS + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // pin input vector positions
  localparam int unsigned PIN_W     = 3;
  localparam int unsigned PIN_OK    = 0;
  localparam int unsigned PIN_LO    = 1;
  localparam int unsigned PIN_HI    = 2;
  localparam logic [2:0]  PIN_RST   = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  localparam int unsigned AW        = 2;
  localparam int unsigned DW        = 8;
  localparam logic [1:0]  OFS_CTRL  = 2'h0;
  localparam logic [1:0]  OFS_STAT  = 2'h1;
  localparam int unsigned CTRL_SWEN = 7;
  localparam int unsigned CTRL_RDY  = 0;
  localparam logic        SWEN_RST  = 1'b0;
  localparam int unsigned STAT_POR  = 0;
  localparam int unsigned STAT_POWER_UP_DELAY_TIMER = 1;
  localparam int unsigned STAT_TRIP = 2;
  localparam int unsigned STAT_HOLD = 3;
  localparam int unsigned STAT_WAKE = 4;
  localparam int unsigned STAT_SEEN = 5;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    MODE_OFF  = 2'h0,
    MODE_SW   = 2'h1,
    MODE_WAKE = 2'h2,
    MODE_ON   = 2'h3
  } sup_bor_mode_t;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'h0,
    ST_TIME  = 2'h1,
    ST_READY = 2'h3,
    ST_RUN   = 2'h2
  } sup_state_t;

  typedef struct packed {
    sup_bor_mode_t brown_out_mode_sel;
    logic          brown_out_level_sel;
    logic          power_up_delay_enable_n;
  } sup_cfg_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } sup_bus_t;

endpackage : sup_pkg

/* sup_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module sup_timer #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned W     = $clog2(LIMIT + 1)
) (
  input  wire logic i_clk,    // block clock
  input  wire logic i_resetn, // sync reset, active low
  input  wire logic i_clear,  // restart from zero
  input  wire logic i_run,    // count this cycle
  output logic      o_done    // limit reached, held
);

  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // saturating up-counter, clear wins over run
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      count <= '0;
    else if (i_clear)
      count <= '0;
    else if (i_run && (count != LIM))
      count <= count + W'(1);
  end

  // done is a compare on the count flop only
  assign o_done = (count == LIM);

endmodule : sup_timer
`default_nettype wire

/* sup_reset_seq.sv */
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sup_reset_seq #(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYC = sup_pkg::POWER_UP_DELAY_TIMER_CYC // power-up delay
) (
  input  wire logic              i_clk,       // 10 MHz block clock
  input  wire logic              i_resetn,    // sync reset, active low
  input  wire sup_pkg::sup_cfg_t i_cfg,       // configuration fields
  input  wire logic              i_sleep,     // core is in sleep
  input  wire logic              i_supply_ok, // supply at min level, pin
  input  wire logic [1:0]        i_below_brown_out_threshold, // lo/hi pin
  input  wire sup_pkg::sup_bus_t i_bus,       // register port
  output logic [7:0]             o_rdata,     // read data, next cycle
  output logic                   o_core_reset_hold,   // reset to core
  output logic                   o_wake_hold,         // delay wake-up
  output logic                   o_brown_out_bias_en  // analog enable
);

  logic [sup_pkg::PIN_W-1:0] sync1;
  logic [sup_pkg::PIN_W-1:0] sync2;
  logic [sup_pkg::PIN_W-1:0] sync3;
  logic [sup_pkg::PIN_W-1:0] pin_q;
  sup_pkg::sup_state_t       state;
  sup_pkg::sup_state_t       next_state;
  sup_pkg::sup_bor_mode_t    mode;
  logic                      sw_brown_out_enable;
  logic                      bor_on;
  logic                      next_bor_on;
  logic                      rdy_done;
  logic                      filt_done;
  logic                      power_up_delay_timer_done;
  logic                      por_hold;
  logic                      below_sel;
  logic                      prot_active;
  logic                      below_act;
  logic                      bor_trip;
  logic                      bor_seen;
  logic                      startup_wait;
  logic                      release_ok;
  logic [7:0]                ctrl_val;
  logic [7:0]                stat_val;
  logic                      wr_ctrl;
  logic                      wr_stat;

  assign mode = i_cfg.brown_out_mode_sel;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode, used for the circuit enable and for start-up gating
  function automatic logic mode_enabled(
    input sup_pkg::sup_bor_mode_t m,
    input logic                   sleep,
    input logic                   swen
  );
    logic r;
    r = 1'b0;
    unique case (m)
      sup_pkg::MODE_ON:   r = 1'b1;
      sup_pkg::MODE_WAKE: r = !sleep;
      sup_pkg::MODE_SW:   r = swen;
      sup_pkg::MODE_OFF:  r = 1'b0;
    endcase
    return r;
  endfunction : mode_enabled

  function automatic logic mode_forced(input sup_pkg::sup_bor_mode_t m);
    return (m == sup_pkg::MODE_ON) || (m == sup_pkg::MODE_WAKE);
  endfunction : mode_forced

  ////////////////////////////////////////////////////////////////////////////
  // comparator pins: three flops, a change counts once flops 2 and 3 agree
  // reset value assumes low supply so nothing is released early
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      sync1 <= sup_pkg::PIN_RST;
      sync2 <= sup_pkg::PIN_RST;
      sync3 <= sup_pkg::PIN_RST;
      pin_q <= sup_pkg::PIN_RST;
    end
    else
    begin
      sync1 <= {i_below_brown_out_threshold, i_supply_ok};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_q <= (pin_q & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
    end
  end

  assign por_hold = !pin_q[sup_pkg::PIN_OK];

  assign below_sel = i_cfg.brown_out_level_sel ? pin_q[sup_pkg::PIN_HI]
                                               : pin_q[sup_pkg::PIN_LO];

  ////////////////////////////////////////////////////////////////////////////
  // circuit enable per mode
  assign next_bor_on = mode_enabled(mode, i_sleep, sw_brown_out_enable);

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      bor_on <= 1'b0;
    else
      bor_on <= next_bor_on;
  end

  // circuit settles for a fixed time after it is switched on
  sup_timer #(
    .LIMIT (sup_pkg::RDY_CYC)
  ) u_rdy_tmr (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (!bor_on),
    .i_run    (bor_on),
    .o_done   (rdy_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // protection only once the circuit reports ready
  assign prot_active = bor_on && rdy_done;
  assign below_act   = prot_active && below_sel;

  // dip filter, trips after more than the filter time below
  sup_timer #(
    .LIMIT (sup_pkg::FILT_CYC)
  ) u_filt_tmr (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (!below_act),
    .i_run    (below_act),
    .o_done   (filt_done)
  );

  // trip held while protection is active and supply stays below, released on recovery or when protection drops
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      bor_trip <= 1'b0;
    else
      bor_trip <= below_act && filt_done;
  end

  // sticky trip record, a new trip beats a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      bor_seen <= 1'b0;
    else if (below_act && filt_done)
      bor_seen <= 1'b1;
    else if (wr_stat && i_bus.wdata[sup_pkg::STAT_SEEN])
      bor_seen <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up delay counts only in its state
  sup_timer #(
    .LIMIT (POWER_UP_DELAY_TIMER_CYC)
  ) u_power_up_delay_timer_tmr (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (state != sup_pkg::ST_TIME),
    .i_run    (state == sup_pkg::ST_TIME),
    .o_done   (power_up_delay_timer_done)
  );

  // forced modes wait for ready and good supply
  assign startup_wait = mode_forced(mode) && (!rdy_done || below_sel);
  // both holds gone before the delay may start
  assign release_ok   = !por_hold && !bor_trip;

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequence; any hold sends it back to the start
  always_comb
  begin
    next_state = state;
    unique case (state)
      sup_pkg::ST_HOLD:
      begin
        // delay skipped when its enable bit is one
        if (release_ok)
          next_state = i_cfg.power_up_delay_enable_n ? sup_pkg::ST_READY
                                                     : sup_pkg::ST_TIME;
      end
      sup_pkg::ST_TIME:
      begin
        if (!release_ok)
          next_state = sup_pkg::ST_HOLD;
        else if (power_up_delay_timer_done)
          next_state = sup_pkg::ST_READY;
      end
      sup_pkg::ST_READY:
      begin
        if (!release_ok)
          next_state = sup_pkg::ST_HOLD;
        else if (!startup_wait)
          next_state = sup_pkg::ST_RUN;
      end
      sup_pkg::ST_RUN:
      begin
        if (!release_ok)
          next_state = sup_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      state <= sup_pkg::ST_HOLD;
    else
      state <= next_state;
  end

  // core held unless the sequence has reached run
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_core_reset_hold <= 1'b1;
    else
      o_core_reset_hold <= (next_state != sup_pkg::ST_RUN);
  end

  // only mode 10 delays wake-up; always-on never does
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_wake_hold <= 1'b0;
    else
      o_wake_hold <= (mode == sup_pkg::MODE_WAKE) && !rdy_done;
  end

  assign o_brown_out_bias_en = bor_on;

  ////////////////////////////////////////////////////////////////////////////
  // register port; writes take effect at once, no wait states
  assign wr_ctrl = i_bus.wr && (i_bus.addr == sup_pkg::OFS_CTRL);
  assign wr_stat = i_bus.wr && (i_bus.addr == sup_pkg::OFS_STAT);

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      sw_brown_out_enable <= sup_pkg::SWEN_RST;
    else if (wr_ctrl)
      sw_brown_out_enable <= i_bus.wdata[sup_pkg::CTRL_SWEN];
  end

  // ready bit readable beside the enable
  always_comb
  begin
    ctrl_val = 8'h00;
    ctrl_val[sup_pkg::CTRL_SWEN] = sw_brown_out_enable;
    ctrl_val[sup_pkg::CTRL_RDY]  = rdy_done;
    stat_val = 8'h00;
    stat_val[sup_pkg::STAT_POR]  = por_hold;
    stat_val[sup_pkg::STAT_POWER_UP_DELAY_TIMER] = (state == sup_pkg::ST_TIME);
    stat_val[sup_pkg::STAT_TRIP] = bor_trip;
    stat_val[sup_pkg::STAT_HOLD] = o_core_reset_hold;
    stat_val[sup_pkg::STAT_WAKE] = o_wake_hold;
    stat_val[sup_pkg::STAT_SEEN] = bor_seen;
  end

  // data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_rdata <= 8'h00;
    else if (i_bus.rd && (i_bus.addr == sup_pkg::OFS_CTRL))
      o_rdata <= ctrl_val;
    else if (i_bus.rd && (i_bus.addr == sup_pkg::OFS_STAT))
      o_rdata <= stat_val;
    else
      o_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // low supply keeps core in reset
  a_por_holds_core: assert property (
    por_hold |=> o_core_reset_hold)
    else $error("core released while supply low");

  // delay leaves its state only when done or aborted
  a_power_up_delay_timer_runs_out: assert property (
    (state == sup_pkg::ST_TIME && !power_up_delay_timer_done && release_ok)
      |=> state == sup_pkg::ST_TIME)
    else $error("power-up delay ended early");

  a_power_up_delay_timer_holds: assert property (
    (state == sup_pkg::ST_TIME) |-> o_core_reset_hold)
    else $error("core running during power-up delay");

  // enable bit one skips the delay
  a_power_up_delay_timer_skip: assert property (
    (state == sup_pkg::ST_HOLD && release_ok
      && i_cfg.power_up_delay_enable_n)
      |=> state == sup_pkg::ST_READY)
    else $error("delay not skipped when disabled");

  // delay waits for both holds to clear
  a_power_up_delay_timer_start: assert property (
    (state == sup_pkg::ST_HOLD && !release_ok)
      |=> state == sup_pkg::ST_HOLD)
    else $error("delay started under a hold");

  // trip only after the full filter time below
  a_trip_filtered: assert property (
    $rose(bor_trip) |-> $past(below_act) [*1]
      ##0 $past(filt_done))
    else $error("trip without filter time");

  // sustained dip trips in the cycle after the filter time is done
  a_trip_taken: assert property (
    below_act [*8] ##0 filt_done |=> bor_trip)
    else $error("sustained dip did not trip");

  // off mode never enables the circuit
  a_mode_off: assert property (
    (mode == sup_pkg::MODE_OFF) |=> !o_brown_out_bias_en)
    else $error("circuit on in off mode");

  // always-on stays on asleep and never holds wake
  a_on_in_sleep: assert property (
    (mode == sup_pkg::MODE_ON && i_sleep)
      |=> o_brown_out_bias_en && !o_wake_hold)
    else $error("always-on mode dropped in sleep");

  // mode 10 off in sleep, wake held until ready
  // ready timer clears one edge after the bias drops, wake hold one later
  a_wake_waits: assert property (
    (mode == sup_pkg::MODE_WAKE && i_sleep)
      |=> !o_brown_out_bias_en ##2 o_wake_hold)
    else $error("mode 10 sleep behaviour wrong");

  // software mode goes to run without waiting
  a_sw_no_wait: assert property (
    (mode == sup_pkg::MODE_SW && state == sup_pkg::ST_READY
      && release_ok) |=> state == sup_pkg::ST_RUN)
    else $error("software mode start-up delayed");

  // ready bit read back matches the circuit
  a_ready_read: assert property (
    (i_bus.rd && i_bus.addr == sup_pkg::OFS_CTRL)
      |=> o_rdata[sup_pkg::CTRL_RDY] == $past(rdy_done))
    else $error("ready bit read wrong");

  // forced modes never run before ready
  a_forced_ready: assert property (
    ($fell(o_core_reset_hold) && mode_forced(mode))
      |-> $past(rdy_done))
    else $error("core ran before circuit ready");

  // hold output tracks the sequence state
  a_hold_or: assert property (
    o_core_reset_hold == (state != sup_pkg::ST_RUN))
    else $error("core hold not matching holds");

endmodule : sup_reset_seq
`default_nettype wire

/* sup_testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // short delay count keeps the run brief; the delay bounds below derive from it
  localparam int unsigned PCYC = 50;
  localparam int unsigned RDY  = sup_pkg::RDY_CYC;

  logic               clk;        // block clock
  logic               resetn;     // sync reset, active low
  sup_pkg::sup_cfg_t  cfg;        // configuration fields
  logic               sleep;      // core asleep
  logic               supply_ok;  // supply comparator
  logic [1:0]         below;      // threshold comparators
  sup_pkg::sup_bus_t  bus;        // register port
  logic [7:0]         rdata;      // read data
  logic               core_hold;  // core reset
  logic               wake_hold;  // wake delay
  logic               bias_en;    // brown-out circuit enable
  int                 error_cnt;
  int                 tests_run;
  int                 cycles;
  int                 n;

  sup_reset_seq #(.POWER_UP_DELAY_TIMER_CYC(PCYC)) dut (
    .i_clk                       (clk),
    .i_resetn                    (resetn),
    .i_cfg                       (cfg),
    .i_sleep                     (sleep),
    .i_supply_ok                 (supply_ok),
    .i_below_brown_out_threshold (below),
    .i_bus                       (bus),
    .o_rdata                     (rdata),
    .o_core_reset_hold           (core_hold),
    .o_wake_hold                 (wake_hold),
    .o_brown_out_bias_en         (bias_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, 100 ns period
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // hang guard, well above the thousand or so cycles the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles >= 10000)
    begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // inputs move 1 ns after the edge, outputs are settled by then
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  // one idle edge after each strobe, so the next call never re-drives
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask : wr

  // data stands only in the cycle after the strobe edge
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    cyc(1);
    bus <= '0;
    check(rdata, exp);
    cyc(1);
  endtask : rd

  // bounded wait for the core hold to reach v; count lands in n
  task automatic wait_hold(input logic v, input int lim);
    n = 0;
    while (core_hold !== v && n < lim)
    begin
      cyc(1);
      n = n + 1;
    end
  endtask : wait_hold

  // reset under a fixed configuration, then let the supply come good
  task automatic start(input sup_pkg::sup_bor_mode_t m, input logic lvl,
                       input logic den_n, input logic [1:0] b);
    resetn    <= 1'b0;
    supply_ok <= 1'b0;
    sleep     <= 1'b0;
    below     <= b;
    cfg       <= '{brown_out_mode_sel: m, brown_out_level_sel: lvl,
                   power_up_delay_enable_n: den_n};
    cyc(5);
    resetn <= 1'b1;
    cyc(20);
    check(core_hold, 8'h01);
    supply_ok <= 1'b1;
  endtask : start

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    cfg = '0;
    sleep = 1'b0;
    supply_ok = 1'b0;
    below = 2'h0;
    bus = '0;
    error_cnt = 0;
    tests_run = 0;
    cycles = 0;
    cyc(1);
    check(core_hold, 8'h01);
    check(wake_hold, 8'h00);
    check(bias_en, 8'h00);

    // mode off with delay: comparators ignored, delay timed in full
    start(sup_pkg::MODE_OFF, 1'b0, 1'b0, 2'h3);
    wait_hold(1'b0, PCYC + 40);
    check(n >= PCYC && n <= PCYC + 20, 8'h01);
    check(bias_en, 8'h00);
    rd(sup_pkg::OFS_STAT, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    supply_ok <= 1'b0;
    wait_hold(1'b1, 10);
    check(core_hold, 8'h01);
    rd(sup_pkg::OFS_STAT, 8'h09);
    supply_ok <= 1'b1;
    cyc(PCYC - 5);
    check(core_hold, 8'h01);
    wait_hold(1'b0, 30);
    check(core_hold, 8'h00);
    $display("test off mode done");

    // delay disabled: release follows the supply almost at once
    start(sup_pkg::MODE_OFF, 1'b0, 1'b1, 2'h0);
    wait_hold(1'b0, 40);
    check(n <= 15, 8'h01);
    $display("test no delay done");

    // always on: start waits for ready, filter, trip, sleep
    start(sup_pkg::MODE_ON, 1'b0, 1'b1, 2'h0);
    // ready timer starts at reset release, 20 cycles before the supply
    wait_hold(1'b0, RDY + 60);
    check(n >= RDY - 20 && n <= RDY, 8'h01);
    check(bias_en, 8'h01);
    rd(sup_pkg::OFS_CTRL, 8'h01);
    below <= 2'h1;
    cyc(10);
    below <= 2'h0;
    cyc(30);
    check(core_hold, 8'h00);
    below <= 2'h1;
    wait_hold(1'b1, 40);
    check(core_hold, 8'h01);
    below <= 2'h0;
    wait_hold(1'b0, 40);
    sleep <= 1'b1;
    cyc(5);
    check(bias_en, 8'h01);
    check(wake_hold, 8'h00);
    below <= 2'h1;
    wait_hold(1'b1, 40);
    check(core_hold, 8'h01);
    below <= 2'h0;
    sleep <= 1'b0;
    cyc(3);
    check(wake_hold, 8'h00);
    $display("test always on done");

    // level select: only the chosen comparator counts
    start(sup_pkg::MODE_ON, 1'b1, 1'b1, 2'h1);
    wait_hold(1'b0, RDY + 60);
    check(core_hold, 8'h00);
    below <= 2'h3;
    wait_hold(1'b1, 40);
    check(core_hold, 8'h01);
    $display("test level select done");

    // off in sleep: start waits, sleep drops protection, wake waits
    start(sup_pkg::MODE_WAKE, 1'b0, 1'b0, 2'h0);
    wait_hold(1'b0, RDY + PCYC + 80);
    check(n >= RDY - 20 && n <= RDY + PCYC, 8'h01);
    check(bias_en, 8'h01);
    sleep <= 1'b1;
    cyc(3);
    check(bias_en, 8'h00);
    below <= 2'h1;
    cyc(40);
    check(core_hold, 8'h00);
    below <= 2'h0;
    cyc(5);
    sleep <= 1'b0;
    cyc(20);
    check(wake_hold, 8'h01);
    n = 0;
    while (wake_hold !== 1'b0 && n < RDY + 40)
    begin
      cyc(1);
      n = n + 1;
    end
    check(n < RDY + 40, 8'h01);
    below <= 2'h1;
    wait_hold(1'b1, 40);
    below <= 2'h0;
    wait_hold(1'b0, PCYC + 40);
    check(n >= PCYC && n <= PCYC + 20, 8'h01);
    $display("test off in sleep done");

    // software mode: no start wait, enable bit, ready flag, sleep
    start(sup_pkg::MODE_SW, 1'b0, 1'b1, 2'h1);
    wait_hold(1'b0, 40);
    check(n <= 15, 8'h01);
    check(bias_en, 8'h00);
    rd(sup_pkg::OFS_CTRL, 8'h00);
    wr(sup_pkg::OFS_CTRL, 8'h81);
    cyc(1);
    check(bias_en, 8'h01);
    rd(sup_pkg::OFS_CTRL, 8'h80);
    cyc(RDY);
    rd(sup_pkg::OFS_CTRL, 8'h81);
    wait_hold(1'b1, 40);
    check(core_hold, 8'h01);
    below <= 2'h0;
    wait_hold(1'b0, 40);
    sleep <= 1'b1;
    cyc(5);
    check(bias_en, 8'h01);
    below <= 2'h1;
    wait_hold(1'b1, 40);
    check(core_hold, 8'h01);
    below <= 2'h0;
    sleep <= 1'b0;
    wait_hold(1'b0, 40);
    wr(sup_pkg::OFS_CTRL, 8'h00);
    cyc(1);
    check(bias_en, 8'h00);
    rd(sup_pkg::OFS_STAT, 8'h20);
    wr(sup_pkg::OFS_STAT, 8'h20);
    rd(sup_pkg::OFS_STAT, 8'h00);
    $display("test software mode done");

    end_of_test();
  end
endmodule : testbench
`default_nettype wire
